// [vcctp_core.sv]
// voice channel coefficient decode, test states and companding
// Contract
// - term is sign bit plus 3-bit shift
// - sign 0 positive, 1 negative
// - shift code is plain binary count
// - shifts and signs accumulate over terms
// - term one is most significant
// - term count limited per filter kind
// - transmit gain uses one plus value
// - transmit cutoff tristates output and strobe
// - receive cutoff zeroes receive, blocks others
// - filter disable bypasses transmit highpass
// - extra loss halves receive signal
// - CDh reads transmit data, parallel mode
// - armed interrupt on new data, read clears
// - interface loopback overwrites transmit data
// - digital loopback routes output to input
// - scaling code 10000 enters digital loopback
// - test tone replaces receive signal
// - a-law or mu-law selected by configuration
// - a-law sixteen-interval segments, top 11110000
// - even bits inverted, code 128 plus n
// - first bit zero for negative samples
// - decoder outputs interval midpoint
`timescale 1ns/1ps
module vcctp_core
    import vcctp_pkg::*;
(
    input wire logic pclk, // 250 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic [7:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic sample_strobe, // one pulse per 8 kHz sample
    input wire logic [7:0] rx_pcm_in, // receive pcm byte
    input wire logic [SW-1:0] analog_input, // converter sample
    output logic [SW-1:0] analog_output, // receive sample out
    output logic analog_out_en, // analog output on
    output logic impedance_scaling_en, // scaling path on
    output logic [7:0] pcm_transmit_out, // transmit pcm byte
    output logic pcm_out_oe, // transmit byte drive
    output logic slot_strobe_n, // slot strobe, low active
    output logic slot_strobe_oe, // strobe drive
    output logic tx_irq // transmit data interrupt
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [4:0] imps_q;
    logic [18:0] coef_q;
    logic [15:0] gain_q;
    logic [7:0] mpi_data_q;
    logic [7:0] tx_code_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [2:0] tone_ph_q;
    logic signed [31:0] x_prev_q;
    logic signed [31:0] y_prev_q;
    logic [SW-1:0] aout_q;
    logic aout_en_q;
    logic impedance_scaling_en_q;
    logic [7:0] pcm_out_q;
    logic pcm_oe_q;
    logic strobe_n_q;
    logic strobe_oe_q;
    logic wr_en;
    logic fdl_eff;
    logic cd_read;
    logic signed [31:0] rx_lin;
    logic signed [31:0] rx_proc;
    logic signed [31:0] tx_src;
    logic signed [31:0] hp;
    logic signed [31:0] tx_g;
    logic [7:0] tx_byte;
    logic signed [31:0] coef_val;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // terms per coefficient by filter kind
    function automatic logic [2:0] nterms(input logic [2:0] kind);
        unique case (kind)
            K_BFIR: return 3'd3;
            K_ZPOST: return 3'd2;
            default: return 3'd4;
        endcase
    endfunction

    // signed-digit shift-add of x; term one sits in the low nibble
    function automatic logic signed [31:0] csd_mul(
        input logic signed [31:0] x,
        input logic [15:0] f,
        input logic [2:0] n
    );
        logic signed [31:0] acc;
        logic neg;
        logic [4:0] sh;
        acc = '0;
        neg = 1'b0;
        sh = '0;
        for (int k = 0; k < 4; k++)
        begin
            if (k < int'(n))
            begin
                neg = neg ^ f[4*k+3];
                sh = sh + {2'b00, f[4*k+:3]};
                acc = neg ? acc - (x >>> sh) : acc + (x >>> sh);
            end
        end
        return acc;
    endfunction

    function automatic logic [11:0] mag12(input logic signed [31:0] x);
        logic signed [31:0] a;
        a = x[31] ? -x : x;
        return (a > MAG_MAX) ? 12'hFFF : a[11:0];
    endfunction

    function automatic logic [7:0] alaw_enc(input logic signed [31:0] x);
        logic [11:0] m;
        logic [2:0] s;
        logic [3:0] man;
        m = mag12(x);
        s = '0;
        for (int b = 5; b < 12; b++)
        begin
            if (m[b])
                s = 3'(b - 4);
        end
        man = (s == 3'd0) ? m[4:1] : 4'(m >> s);
        return {~x[31], s, man} ^ ALAW_INV;
    endfunction

    function automatic logic signed [31:0] alaw_dec(input logic [7:0] c);
        logic [7:0] p;
        logic signed [31:0] y;
        p = c ^ ALAW_INV;
        if (p[6:4] == 3'd0)
            y = 32'({p[3:0], 1'b1});
        else
            y = (32'({1'b1, p[3:0]}) << p[6:4])
                + (32'sd1 << (p[6:4] - 3'd1));
        return p[7] ? y : -y;
    endfunction

    function automatic logic [7:0] mulaw_enc(input logic signed [31:0] x);
        logic [13:0] b;
        logic [2:0] s;
        logic [12:0] m2;
        m2 = {mag12(x), 1'b0};
        b = (int'(m2) > MU_CLIP) ? 14'(MU_CLIP + MU_BIAS)
            : 14'(int'(m2) + MU_BIAS);
        s = '0;
        for (int k = 6; k < 13; k++)
        begin
            if (b[k])
                s = 3'(k - 5);
        end
        return ~{x[31], s, 4'(b >> (s + 3'd1))};
    endfunction

    function automatic logic signed [31:0] mulaw_dec(input logic [7:0] c);
        logic [7:0] u;
        logic signed [31:0] t;
        u = ~c;
        t = ((32'({u[3:0], 1'b1}) + 32'sd32) << u[6:4]) - MU_BIAS;
        t = t >>> 1;
        return u[7] ? -t : t;
    endfunction

    function automatic logic signed [31:0] tone_val(input logic [2:0] ph);
        unique case (ph[1:0])
            2'd0: tone_val = '0;
            2'd2: tone_val = TONE_PEAK;
            default: tone_val = TONE_MID;
        endcase
        if (ph[2])
            tone_val = -tone_val;
    endfunction

    assign wr_en = psel & penable & pready_q & pwrite;
    assign cd_read = wr_en & (paddr == ADDR_CMD)
        & (pwdata[7:0] == CMD_READ_TX) & ctrl_q[B_PAR];
    assign fdl_eff = ctrl_q[B_FDL] | (imps_q == IMPEDANCE_SCALING_FDL_CODE);
    assign coef_val = csd_mul(ONE_Q, coef_q[15:0], nterms(coef_q[18:16]))
        + ((coef_q[18:16] == K_GX) ? ONE_Q : 32'sd0);

    always_comb
    begin
        rx_lin = ctrl_q[B_ALAW] ? alaw_dec(rx_pcm_in)
            : mulaw_dec(rx_pcm_in);
        if (ctrl_q[B_TONE])
            rx_lin = tone_val(tone_ph_q);
        if (ctrl_q[B_RXCUT])
            rx_lin = '0;
        rx_proc = ctrl_q[B_LOSS] ? (rx_lin >>> 1) : rx_lin;
        tx_src = fdl_eff ? rx_proc
            : 32'(signed'(analog_input));
        hp = ctrl_q[B_HPDIS] ? tx_src
            : tx_src - x_prev_q + y_prev_q
                - (y_prev_q >>> HPF_SHIFT);
        tx_g = hp + csd_mul(hp, gain_q, 3'd4);
        if (ctrl_q[B_ILB] | ctrl_q[B_TLB])
            tx_byte = rx_pcm_in;
        else if (ctrl_q[B_ALAW])
            tx_byte = alaw_enc(tx_g);
        else
            tx_byte = mulaw_enc(tx_g);
    end

    // apb: one wait-free access phase, answer prepared in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & (paddr[1:0] != 2'b00
                || paddr > ADDR_GAIN);
            if (psel & ~penable)
            begin
                unique case (paddr)
                    ADDR_CTRL: prdata_q <= 32'(ctrl_q);
                    ADDR_IMPS: prdata_q <= 32'(imps_q);
                    ADDR_COEF: prdata_q <= 32'(coef_q);
                    ADDR_CVAL: prdata_q <= coef_val;
                    ADDR_MPID: prdata_q <= 32'(mpi_data_q);
                    ADDR_STAT: prdata_q <= {30'd0, fdl_eff, irq_q};
                    ADDR_GAIN: prdata_q <= 32'(gain_q);
                    default: prdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            imps_q <= IMPS_RST;
            coef_q <= COEF_RST;
            gain_q <= GAIN_RST;
        end
        else if (wr_en)
        begin
            if (paddr == ADDR_CTRL)
                ctrl_q <= pwdata[CTRL_W-1:0];
            if (paddr == ADDR_IMPS)
                imps_q <= pwdata[4:0];
            if (paddr == ADDR_COEF)
                coef_q <= pwdata[18:0];
            if (paddr == ADDR_GAIN)
                gain_q <= pwdata[15:0];
        end
    end

    // microprocessor copy of transmit data and its interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mpi_data_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (cd_read)
                mpi_data_q <= tx_code_q;
            if (sample_strobe & ctrl_q[B_ARM])
                irq_q <= 1'b1;
            else if (cd_read)
                irq_q <= 1'b0;
        end
    end

    // per-sample datapath state and pin outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tone_ph_q <= '0;
            x_prev_q <= '0;
            y_prev_q <= '0;
            tx_code_q <= '0;
            aout_q <= '0;
            aout_en_q <= 1'b1;
            impedance_scaling_en_q <= 1'b1;
            pcm_out_q <= '0;
            pcm_oe_q <= 1'b0;
            strobe_n_q <= 1'b1;
            strobe_oe_q <= 1'b0;
        end
        else
        begin
            aout_en_q <= ~fdl_eff;
            impedance_scaling_en_q <= ~fdl_eff;
            strobe_n_q <= 1'b1;
            pcm_oe_q <= 1'b0;
            strobe_oe_q <= ~ctrl_q[B_TXCUT];
            if (sample_strobe)
            begin
                tone_ph_q <= tone_ph_q + 3'd1;
                x_prev_q <= tx_src;
                y_prev_q <= hp;
                tx_code_q <= tx_byte;
                aout_q <= fdl_eff ? '0 : rx_proc[SW-1:0];
                if (!ctrl_q[B_TXCUT])
                begin
                    pcm_out_q <= tx_byte;
                    pcm_oe_q <= 1'b1;
                    strobe_n_q <= 1'b0;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_output = aout_q;
    assign analog_out_en = aout_en_q;
    assign impedance_scaling_en = impedance_scaling_en_q;
    assign pcm_transmit_out = pcm_out_q;
    assign pcm_out_oe = pcm_oe_q;
    assign slot_strobe_n = strobe_n_q;
    assign slot_strobe_oe = strobe_oe_q;
    assign tx_irq = irq_q;

    a_cut_tristate: assert property (ctrl_q[B_TXCUT]
        |=> !pcm_oe_q && !strobe_oe_q)
        else $error("transmit driven while cut off");
    a_slot_pulse: assert property (sample_strobe
        && !ctrl_q[B_TXCUT] |=> (pcm_oe_q && !strobe_n_q) ##1 strobe_n_q)
        else $error("slot strobe not one cycle");
    a_rx_cut_zero: assert property (ctrl_q[B_RXCUT]
        && sample_strobe |=> aout_q == '0)
        else $error("receive cutoff let signal through");
    a_fdl_code: assert property (imps_q == IMPEDANCE_SCALING_FDL_CODE
        |=> !aout_en_q && !impedance_scaling_en_q)
        else $error("scaling code did not force loopback");
    a_irq_sets: assert property (sample_strobe && ctrl_q[B_ARM]
        |=> irq_q ##1 (irq_q || $past(cd_read)))
        else $error("armed interrupt not raised");
    a_irq_clears: assert property (cd_read && !sample_strobe
        |=> !irq_q)
        else $error("read did not clear interrupt");
    a_cd_copy: assert property (cd_read
        |=> mpi_data_q == $past(tx_code_q))
        else $error("read command did not copy data");
    a_cd_parallel: assert property (wr_en && paddr == ADDR_CMD
        && !ctrl_q[B_PAR] |=> $stable(mpi_data_q))
        else $error("read command outside parallel mode");
    a_ilb_copy: assert property (sample_strobe && ctrl_q[B_ILB]
        && !ctrl_q[B_TXCUT] |=> pcm_out_q == $past(rx_pcm_in))
        else $error("interface loopback lost receive byte");
    a_apb_ready: assert property (psel && !penable
        |=> pready_q ##1 !pready_q)
        else $error("apb ready not single cycle");
endmodule

// [vcctp_pkg.sv]
// constants for the voice channel coefficient and test path block
package vcctp_pkg;
    localparam int SW = 13;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IMPS = 8'h04;
    localparam logic [7:0] ADDR_COEF = 8'h08;
    localparam logic [7:0] ADDR_CVAL = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_MPID = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_GAIN = 8'h1C;
    localparam int B_TXCUT = 0;
    localparam int B_RXCUT = 1;
    localparam int B_HPDIS = 2;
    localparam int B_LOSS = 3;
    localparam int B_ARM = 4;
    localparam int B_ILB = 5;
    localparam int B_FDL = 6;
    localparam int B_TLB = 7;
    localparam int B_TONE = 8;
    localparam int B_ALAW = 9;
    localparam int B_PAR = 10;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RST = 11'h600;
    localparam logic [4:0] IMPS_RST = 5'h00;
    localparam logic [4:0] IMPEDANCE_SCALING_FDL_CODE = 5'h10;
    localparam logic [7:0] CMD_READ_TX = 8'hCD;
    localparam logic [18:0] COEF_RST = 19'h00000;
    localparam logic [15:0] GAIN_RST = 16'h0000;
    localparam logic [7:0] ALAW_INV = 8'h55;
    localparam logic signed [31:0] ONE_Q = 32'sh1000_0000;
    localparam logic signed [31:0] TONE_PEAK = 32'sh0000_0B10;
    localparam logic signed [31:0] TONE_MID = 32'sh0000_07D3;
    localparam int HPF_SHIFT = 4;
    localparam int MAG_MAX = 4095;
    localparam int MU_CLIP = 8158;
    localparam int MU_BIAS = 33;
    localparam logic [2:0] K_GR = 3'h0;
    localparam logic [2:0] K_GX = 3'h1;
    localparam logic [2:0] K_R = 3'h2;
    localparam logic [2:0] K_X = 3'h3;
    localparam logic [2:0] K_Z = 3'h4;
    localparam logic [2:0] K_BIIR = 3'h5;
    localparam logic [2:0] K_BFIR = 3'h6;
    localparam logic [2:0] K_ZPOST = 3'h7;
endpackage

// [vcctp_far.sv]
// partner model of the pcm highway and sample timing
`timescale 1ns/1ps
module vcctp_far
    import vcctp_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic fire, // send one sample
    input wire logic [7:0] rx_byte, // byte to send
    input wire logic [SW-1:0] ana_val, // sample to send
    output logic sample_strobe, // sample pulse
    output logic [7:0] rx_pcm_in, // highway byte
    output logic [SW-1:0] analog_input, // converter sample
    input wire logic [7:0] pcm_transmit_out, // transmit byte
    input wire logic pcm_out_oe, // transmit drive
    input wire logic slot_strobe_n, // slot strobe
    output logic [7:0] got_byte, // last byte taken
    output int got_cnt // slots seen
);
    // lines scrambled outside the strobe cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_strobe <= 1'b0;
            rx_pcm_in <= 8'h00;
            analog_input <= '0;
        end
        else
        begin
            sample_strobe <= fire;
            rx_pcm_in <= fire ? rx_byte : ~rx_pcm_in;
            analog_input <= fire ? ana_val : ~analog_input;
        end
    end
    // a slot counts if the byte is driven or the strobe is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            got_cnt <= 0;
            got_byte <= 8'h00;
        end
        else if (pcm_out_oe === 1'b1 || slot_strobe_n === 1'b0)
        begin
            got_cnt <= got_cnt + 1;
            got_byte <= pcm_transmit_out;
        end
    end
endmodule

// [test_voice_channel_coeff_test_path.sv]
// self-checking bench for the voice channel path
`timescale 1ns/1ps
module test_voice_channel_coeff_test_path;
    import vcctp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, err;
    logic sample_strobe, analog_out_en, impedance_scaling_en, pcm_out_oe;
    logic slot_strobe_n, slot_strobe_oe, tx_irq;
    logic [7:0] paddr, rx_byte, rx_pcm_in, pcm_transmit_out, got_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [SW-1:0] analog_input, analog_output, ana_val;
    int n_errors, checks_done, got_cnt;

    vcctp_core dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .sample_strobe, .rx_pcm_in,
        .analog_input, .analog_output, .analog_out_en,
        .impedance_scaling_en, .pcm_transmit_out, .pcm_out_oe,
        .slot_strobe_n, .slot_strobe_oe, .tx_irq);
    vcctp_far far (.pclk, .presetn, .fire, .rx_byte, .ana_val,
        .sample_strobe, .rx_pcm_in, .analog_input, .pcm_transmit_out,
        .pcm_out_oe, .slot_strobe_n, .got_byte, .got_cnt);

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk_reg(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [SW-1:0] e,
        input logic [SW-1:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one sample through the far side, outputs settled on return
    task automatic smp(input logic [7:0] b, input logic [SW-1:0] v);
        @(posedge pclk);
        fire <= 1'b1;
        rx_byte <= b;
        ana_val <= v;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask

    function automatic logic [7:0] a_enc(input int x);
        int m, e;
        m = (x < 0) ? -x : x;
        m = (m > MAG_MAX) ? MAG_MAX : m;
        e = 0;
        while ((m >> (e + 5)) != 0)
            e++;
        m = (e == 0) ? m >> 1 : m >> e;
        return {x >= 0, 3'(e), 4'(m)} ^ 8'h55;
    endfunction

    function automatic int a_dec(input logic [7:0] c);
        logic [7:0] p;
        int y;
        p = c ^ 8'h55;
        y = (p[6:4] == 0) ? 2 * p[3:0] + 1 : (2 * p[3:0] + 33) << (p[6:4] - 1);
        return p[7] ? y : -y;
    endfunction

    function automatic int csd(input logic [18:0] c);
        int acc, sh, sg, nt;
        acc = 0;
        sh = 0;
        sg = 1;
        nt = (c[18:16] == K_BFIR) ? 3 : (c[18:16] == K_ZPOST) ? 2 : 4;
        for (int t = 0; t < nt; t++)
        begin
            sh += c[4*t +: 3];
            if (c[4*t+3])
                sg = -sg;
            acc += sg * (ONE_Q >>> sh);
        end
        return (c[18:16] == K_GX) ? acc + ONE_Q : acc;
    endfunction

    initial
    begin
        #80000;
        n_errors++;
        test_done();
    end

    initial
    begin
        int v, y, x1, y1;
        int tv[10];
        logic [7:0] b;
        logic [18:0] cf;
        n_errors = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fire = 1'b0;
        rx_byte = 8'h00;
        ana_val = '0;
        tv = '{0, 31, 32, 2047, 2048, 2175, 4095, -1, -2048, -4096};
        v = $urandom(32'h6B8E);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk_reg("ctrl_rst", 32'(CTRL_RST), rd);
        apb(1'b0, 8'h20, 32'h0);
        chk_reg("unmapped", 32'h1, rd | 32'(err));
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h002));
        apb(1'b1, ADDR_GAIN, 32'h0000_8080);
        x1 = 0;
        y1 = 0;
        repeat (4)
        begin
            v = $urandom_range(1400, 0) - 700;
            smp(8'hD5, SW'(v));
            y = v - x1 + y1 - (y1 >>> 4);
            x1 = v;
            y1 = y;
            chk_pin("hp_byte", SW'(a_enc(y)), SW'(got_byte));
        end
        $display("test highpass done");
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h006));
        foreach (tv[i])
        begin
            smp(8'($urandom), SW'(tv[i]));
            chk_pin("alaw", SW'(a_enc(tv[i])), SW'(got_byte));
            chk_pin("rx_cut", '0, analog_output);
        end
        apb(1'b1, ADDR_GAIN, 32'h0000_0888);
        smp(8'h00, SW'(1000));
        chk_pin("gain_neg", SW'(a_enc(-1000)), SW'(got_byte));
        apb(1'b1, ADDR_GAIN, 32'h0000_8080);
        apb(1'b1, ADDR_CTRL, 32'h406);
        smp(8'h00, '0);
        chk_pin("mu_zero", 13'h00FF, SW'(got_byte));
        $display("test encode done");
        b = 8'($urandom);
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST));
        smp(b, '0);
        chk_pin("rx_dec", SW'(a_dec(b)), analog_output);
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h008));
        smp(b, '0);
        chk_pin("rx_loss", SW'(a_dec(b) >>> 1), analog_output);
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h102));
        smp(b, '0);
        chk_pin("tone_cut", '0, analog_output);
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h100));
        y = 0;
        x1 = 0;
        repeat (8)
        begin
            smp(b, '0);
            y += int'(signed'(analog_output));
            x1 += (int'(signed'(analog_output)) == TONE_PEAK) ? 1 : 0;
        end
        chk_reg("tone_sum", 32'h0, y);
        chk_reg("tone_peak", 32'h1, x1);
        $display("test receive done");
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h030));
        smp(b, SW'(v));
        chk_pin("ilb_byte", SW'(b), SW'(got_byte));
        chk_pin("irq_set", 13'h0001, SW'(tx_irq));
        apb(1'b0, ADDR_STAT, 32'h0);
        chk_reg("stat_irq", 32'h1, rd & 32'h1);
        apb(1'b1, ADDR_CMD, 32'(CMD_READ_TX));
        apb(1'b0, ADDR_MPID, 32'h0);
        chk_reg("cd_copy", 32'(b), rd);
        chk_pin("irq_clr", '0, SW'(tx_irq));
        apb(1'b1, ADDR_CTRL, 32'h230);
        smp(~b, '0);
        apb(1'b1, ADDR_CMD, 32'(CMD_READ_TX));
        apb(1'b0, ADDR_MPID, 32'h0);
        chk_reg("cd_serial", 32'(b), rd);
        chk_pin("irq_hold", 13'h0001, SW'(tx_irq));
        $display("test loopback irq done");
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST | 11'h0C1));
        v = got_cnt;
        smp(b, '0);
        chk_pin("cut_slots", SW'(v), SW'(got_cnt));
        chk_pin("cut_oe", '0, SW'(slot_strobe_oe));
        chk_pin("fdl_out", '0, SW'(analog_out_en));
        apb(1'b1, ADDR_CTRL, 32'(CTRL_RST));
        apb(1'b1, ADDR_IMPS, 32'(IMPEDANCE_SCALING_FDL_CODE));
        apb(1'b0, ADDR_STAT, 32'h0);
        chk_reg("stat_fdl", 32'h2, rd & 32'h2);
        chk_pin("scale_off", '0, SW'(impedance_scaling_en));
        apb(1'b1, ADDR_IMPS, 32'h0000_000F);
        repeat (2) @(negedge pclk);
        chk_pin("scale_on", 13'h0001, SW'(impedance_scaling_en));
        $display("test cutoff fdl done");
        for (int i = 0; i < 32; i++)
        begin
            cf = {3'(i), 16'($urandom)};
            apb(1'b1, ADDR_COEF, 32'(cf));
            apb(1'b0, ADDR_CVAL, 32'h0);
            chk_reg("coef_val", csd(cf), rd);
        end
        $display("test coefficient done");
        test_done();
    end
endmodule
